// File: verification/sstd_pm_model.sv
`default_nettype none
module sstd_pm_model
   import sstd_pkg::*;
(
   input  wire logic               ref_clk_i,
   input  wire logic               rd_i,
   input  wire logic               wr_i,
   input  wire logic               wr_hi_i,
   input  wire logic [SSTD_AW-1:0] addr_i,
   input  wire logic [SSTD_PW-1:0] wdata_i,
   output logic [SSTD_PW-1:0]      rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // program memory, sixteen words seen through the low address bits
   logic [SSTD_PW-1:0] mem [16];
   logic [7:0]         junk_reg = 8'h00;
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 24'(i) * 24'h111111;
      end
   end
   // outside a read strobe the bus churns so stale data is never mistaken for a fetch
   assign rdata_o = rd_i ? mem[addr_i[3:0]] : {3{junk_reg}};
   always @(posedge ref_clk_i) begin
      junk_reg <= junk_reg + 8'h5b;
      if (wr_i && wr_hi_i) begin
         mem[addr_i[3:0]][23:16] <= wdata_i[23:16];
      end
      if (wr_i && !wr_hi_i) begin
         mem[addr_i[3:0]][15:0] <= wdata_i[15:0];
      end
   end
endmodule : sstd_pm_model
`default_nettype wire

// File: verification/test_sstd_datapath.sv
`default_nettype none
module test_sstd_datapath;
   import sstd_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, ready_o, done_o, wr_en_o, pm_rd_o, pm_wr_o, pm_wr_hi_o;
   sstd_req_t req_i = '0;
   sstd_flags_t flags_o, ef = '0;
   logic [SSTD_RW-1:0] wr_dst_o;
   logic [SSTD_DW-1:0] wr_data_o;
   logic [SSTD_AW-1:0] pm_addr_o;
   logic [SSTD_PW-1:0] pm_rdata_i, pm_wdata_o;
   int n_mismatch = 0, checks_done = 0, cyc = 0;
   always #50 ref_clk_i = ~ref_clk_i;
   sstd_datapath dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .pm_rdata_i(pm_rdata_i),
      .ready_o(ready_o), .done_o(done_o), .wr_en_o(wr_en_o), .wr_dst_o(wr_dst_o), .wr_data_o(wr_data_o),
      .flags_o(flags_o), .pm_rd_o(pm_rd_o), .pm_wr_o(pm_wr_o), .pm_wr_hi_o(pm_wr_hi_o),
      .pm_addr_o(pm_addr_o), .pm_wdata_o(pm_wdata_o));
   sstd_pm_model pm (.ref_clk_i(ref_clk_i), .rd_i(pm_rd_o), .wr_i(pm_wr_o), .wr_hi_i(pm_wr_hi_o),
      .addr_i(pm_addr_o), .wdata_i(pm_wdata_o), .rdata_o(pm_rdata_i));
   // ==========================================================
   // checking and closing
   task automatic check(string nm, logic [23:0] seen, logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_mismatch++;
         test_done();
      end
   end
   // ==========================================================
   // one arithmetic request, kept valid so calls run back to back
   task automatic alu(sstd_op_t op, logic ul, logic [4:0] l, logic [15:0] a, logic [15:0] b);
      logic [16:0] d;
      logic [4:0]  dn;
      logic [15:0] r, x, s;
      logic        bw;
      bw = ~ef.c;
      if (op == SSTD_OP_SHIFT_LEFT) r = a << (ul ? l[3:0] : b[3:0]);
      else if (op == SSTD_OP_ZERO_EXTEND) begin
         r = {8'h00, a[7:0]};
         ef.c = 1'b1;
      end else begin
         x = (op == SSTD_OP_REVERSE_SUBTRACT_WITH_BORROW_OP) ? b : a;
         s = (op == SSTD_OP_SUBTRACT_WITH_BORROW_OP && ul) ? {11'h000, l} : ((op == SSTD_OP_REVERSE_SUBTRACT_WITH_BORROW_OP) ? a : b);
         d = {1'b0, x} - {1'b0, s} - {16'h0000, bw};
         dn = {1'b0, x[3:0]} - {1'b0, s[3:0]} - {4'h0, bw};
         r = d[15:0];
         ef.c = ~d[16];
         ef.dc = ~dn[4];
         ef.ov = (x[15] != s[15]) && (r[15] != x[15]);
      end
      ef.n = r[15];
      ef.z = (r == 16'h0000);
      req_i <= '{valid: 1'b1, op: op, use_lit: ul, lit: l, a: a, b: b, dst: b[3:0] ^ 4'ha, addr: 16'h0000};
      @(posedge ref_clk_i) #1;
      check("alu done", {wr_en_o, done_o}, 24'h3);
      check("alu data", wr_data_o, r);
      check("alu dest", wr_dst_o, b[3:0] ^ 4'ha);
      check("alu flags", flags_o, ef);
   endtask : alu
   // ==========================================================
   // one table access; a request during its busy cycle must be dropped
   task automatic tbl(sstd_op_t op, logic [15:0] a, logic [15:0] ad, logic [15:0] exp);
      logic rd;
      rd = (op == SSTD_OP_TBL_READ_HI) || (op == SSTD_OP_TBL_READ_LO);
      req_i <= '{valid: 1'b1, op: op, use_lit: 1'b0, lit: 5'h00, a: a, b: 16'h0000, dst: 4'h6, addr: ad};
      @(posedge ref_clk_i) #1;
      check("tbl busy", {ready_o, done_o, pm_rd_o, pm_wr_o}, {3'b000, !rd} | {2'b00, rd, 1'b0});
      check("tbl addr", pm_addr_o, ad);
      if (!rd) check("tbl wdata", op == SSTD_OP_TBL_WRITE_HI ? {pm_wr_hi_o, pm_wdata_o[23:16]} :
         {pm_wr_hi_o, pm_wdata_o[15:0]}, exp);
      req_i.op <= SSTD_OP_ZERO_EXTEND;
      @(posedge ref_clk_i) #1;
      req_i.valid <= 1'b0;
      check("tbl end", {ready_o, done_o, wr_en_o}, {2'b11, rd});
      if (rd) check("tbl rdata", {wr_dst_o, wr_data_o}, {4'h6, exp[15:0]});
      check("tbl flags", flags_o, ef);
      @(posedge ref_clk_i) #1;
      check("tbl drop", {done_o, wr_en_o}, 24'h0);
   endtask : tbl
   task automatic t_alu();
      alu(SSTD_OP_SHIFT_LEFT, 1'b0, 5'h00, 16'h8ce1, 16'h0013);
      alu(SSTD_OP_SHIFT_LEFT, 1'b1, 5'h1f, 16'h0003, 16'h0004);
      alu(SSTD_OP_SHIFT_LEFT, 1'b1, 5'h00, 16'h0000, 16'h0007);
      alu(SSTD_OP_ZERO_EXTEND, 1'b0, 5'h00, 16'hf39c, 16'h0001);
      alu(SSTD_OP_REVERSE_SUBTRACT_WITH_BORROW_OP, 1'b0, 5'h00, 16'h0009, 16'h0005);
      alu(SSTD_OP_SUBTRACT_WITH_BORROW_OP, 1'b1, 5'h1f, 16'h0020, 16'h0002);
      alu(SSTD_OP_SUBTRACT_WITH_BORROW_OP, 1'b0, 5'h00, 16'h8000, 16'h0001);
      alu(SSTD_OP_REVERSE_SUBTRACT_WITH_BORROW_OP, 1'b0, 5'h00, 16'h0001, 16'h0001);
      // an undefined code completes without a write and keeps the flags
      req_i.op <= sstd_op_t'(4'h9);
      @(posedge ref_clk_i) #1;
      req_i.valid <= 1'b0;
      check("bad op", {done_o, wr_en_o}, 24'h2);
      check("bad op flags", flags_o, ef);
      @(posedge ref_clk_i) #1;
      $display("test alu finished");
   endtask : t_alu
   task automatic t_tbl();
      tbl(SSTD_OP_TBL_WRITE_HI, 16'h12ab, 16'h0003, 24'h1ab);
      tbl(SSTD_OP_TBL_WRITE_LO, 16'h5e71, 16'h0003, 24'h05e71);
      tbl(SSTD_OP_TBL_READ_HI, 16'h0000, 16'h0003, 24'h00ab);
      tbl(SSTD_OP_TBL_READ_LO, 16'h0000, 16'h0003, 24'h5e71);
      tbl(SSTD_OP_TBL_READ_HI, 16'h0000, 16'h0005, 24'h0055);
      tbl(SSTD_OP_TBL_READ_LO, 16'h0000, 16'h000f, 24'hffff);
      $display("test table finished");
   endtask : t_tbl
   initial begin
      repeat (8) @(posedge ref_clk_i);
      #1 rst_n_i = 1'b1;
      check("reset", {ready_o, done_o, wr_en_o, pm_rd_o, pm_wr_o, flags_o}, 24'h200);
      t_alu();
      t_tbl();
      test_done();
   end
endmodule : test_sstd_datapath
`default_nettype wire

// File: verilog/sstd_datapath.sv
`default_nettype none
module sstd_datapath
   import sstd_pkg::*;
(
   input  wire logic               ref_clk_i,
   input  wire logic               rst_n_i,
   input  wire sstd_req_t          req_i,
   input  wire logic [SSTD_PW-1:0] pm_rdata_i,
   output logic                    ready_o,
   output logic                    done_o,
   output logic                    wr_en_o,
   output logic [SSTD_RW-1:0]      wr_dst_o,
   output logic [SSTD_DW-1:0]      wr_data_o,
   output sstd_flags_t             flags_o,
   output logic                    pm_rd_o,
   output logic                    pm_wr_o,
   output logic                    pm_wr_hi_o,
   output logic [SSTD_AW-1:0]      pm_addr_o,
   output logic [SSTD_PW-1:0]      pm_wdata_o
);
   // ==========================================================
   // state
   sstd_regs_t state_reg;
   sstd_regs_t state_next;

   logic [SSTD_DW-1:0] opnd_b;
   logic [SSTD_DW:0]   diff;
   logic [4:0]         ndiff;
   logic [SSTD_DW-1:0] x_op;
   logic [SSTD_DW-1:0] y_op;
   logic               borrow_in;
   logic [SSTD_DW-1:0] shifted;

   assign ready_o = (state_reg.st == SSTD_ST_IDLE);

   // ==========================================================
   // elaboration check
   // the two-state walk below serves a table access of exactly two cycles
   if (SSTD_TBL_CYCLES != 2) begin : g_tbl_len
      $error("table access length must be two cycles");
   end

   // ==========================================================
   // arithmetic
   always_comb begin
      opnd_b    = req_i.use_lit ? {{(SSTD_DW-SSTD_LITW){1'b0}}, req_i.lit} : req_i.b;
      // subtract-with-borrow takes one extra when carry is clear
      borrow_in = ~state_reg.flags.c;
      if (req_i.op == SSTD_OP_REVERSE_SUBTRACT_WITH_BORROW_OP) begin
         x_op = req_i.b;
         y_op = req_i.a;
      end else begin
         x_op = req_i.a;
         y_op = opnd_b;
      end
      diff    = {1'b0, x_op} - {1'b0, y_op} - {{SSTD_DW{1'b0}}, borrow_in};
      ndiff   = {1'b0, x_op[SSTD_NIB_MSB:0]} - {1'b0, y_op[SSTD_NIB_MSB:0]} - {4'h0, borrow_in};
      // only the low four bits of the amount count; larger shifts wrap
      shifted = req_i.a << opnd_b[SSTD_SHW-1:0];
   end

   // ==========================================================
   // next state
   always_comb begin
      state_next       = state_reg;
      state_next.wr_en = 1'b0;
      state_next.pm_rd = 1'b0;
      state_next.pm_wr = 1'b0;
      state_next.done  = 1'b0;
      unique case (state_reg.st)
         SSTD_ST_IDLE: begin
            if (req_i.valid) begin
               state_next.wr_dst = req_i.dst;
               unique case (req_i.op)
                  SSTD_OP_SHIFT_LEFT: begin
                     state_next.wr_en   = 1'b1;
                     state_next.wr_data = shifted;
                     state_next.flags.n = shifted[SSTD_DW-1];
                     state_next.flags.z = (shifted == SSTD_DATA_RST);
                     state_next.done    = 1'b1;
                  end
                  SSTD_OP_SUBTRACT_WITH_BORROW_OP, SSTD_OP_REVERSE_SUBTRACT_WITH_BORROW_OP: begin
                     state_next.wr_en    = 1'b1;
                     state_next.wr_data  = diff[SSTD_DW-1:0];
                     state_next.flags.c  = ~diff[SSTD_DW];
                     state_next.flags.dc = ~ndiff[4];
                     state_next.flags.n  = diff[SSTD_DW-1];
                     state_next.flags.ov = (x_op[SSTD_DW-1] != y_op[SSTD_DW-1]) &&
                                           (diff[SSTD_DW-1] != x_op[SSTD_DW-1]);
                     state_next.flags.z  = (diff[SSTD_DW-1:0] == SSTD_DATA_RST);
                     state_next.done     = 1'b1;
                  end
                  SSTD_OP_ZERO_EXTEND: begin
                     state_next.wr_en   = 1'b1;
                     state_next.wr_data = {8'h00, req_i.a[SSTD_BYTE_MSB:0]};
                     // result is never negative and carry is set
                     state_next.flags.c = 1'b1;
                     state_next.flags.n = 1'b0;
                     state_next.flags.z = (req_i.a[SSTD_BYTE_MSB:0] == 8'h00);
                     state_next.done    = 1'b1;
                  end
                  SSTD_OP_TBL_READ_HI, SSTD_OP_TBL_READ_LO,
                  SSTD_OP_TBL_WRITE_HI, SSTD_OP_TBL_WRITE_LO: begin
                     // flags untouched on every table path
                     state_next.st       = SSTD_ST_TABLE;
                     state_next.op       = req_i.op;
                     state_next.addr     = req_i.addr;
                     state_next.dst      = req_i.dst;
                     state_next.pm_wr_hi = (req_i.op == SSTD_OP_TBL_WRITE_HI);
                     state_next.pm_wdata = (req_i.op == SSTD_OP_TBL_WRITE_HI) ?
                        {req_i.a[SSTD_BYTE_MSB:0], 16'h0000} :
                        {8'h00, req_i.a};
                     state_next.pm_rd    = (req_i.op == SSTD_OP_TBL_READ_HI) ||
                                           (req_i.op == SSTD_OP_TBL_READ_LO);
                     state_next.pm_wr    = (req_i.op == SSTD_OP_TBL_WRITE_HI) ||
                                           (req_i.op == SSTD_OP_TBL_WRITE_LO);
                  end
                  default: begin
                     state_next.done = 1'b1;
                  end
               endcase
            end
         end
         SSTD_ST_TABLE: begin
            // second instruction cycle: memory answers during this one, while pm_rd_o is high
            state_next.st   = SSTD_ST_IDLE;
            state_next.done = 1'b1;
            if (state_reg.op == SSTD_OP_TBL_READ_HI) begin
               state_next.wr_en   = 1'b1;
               state_next.wr_dst  = state_reg.dst;
               state_next.wr_data = {8'h00, pm_rdata_i[SSTD_PHI_MSB:SSTD_PHI_LSB]};
            end else if (state_reg.op == SSTD_OP_TBL_READ_LO) begin
               state_next.wr_en   = 1'b1;
               state_next.wr_dst  = state_reg.dst;
               state_next.wr_data = pm_rdata_i[SSTD_DW-1:0];
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg          <= '0;
         state_reg.st       <= SSTD_ST_IDLE;
         state_reg.pm_wdata <= SSTD_PROG_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // outputs
   assign done_o     = state_reg.done;
   assign wr_en_o    = state_reg.wr_en;
   assign wr_dst_o   = state_reg.wr_dst;
   assign wr_data_o  = state_reg.wr_data;
   assign flags_o    = state_reg.flags;
   assign pm_rd_o    = state_reg.pm_rd;
   assign pm_wr_o    = state_reg.pm_wr;
   assign pm_wr_hi_o = state_reg.pm_wr_hi;
   assign pm_addr_o  = state_reg.addr;
   assign pm_wdata_o = state_reg.pm_wdata;

   // ==========================================================
   // checks
   AST_SHIFT_FLAGS: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ready_o && req_i.valid && req_i.op == SSTD_OP_SHIFT_LEFT) |=>
         (flags_o.c == $past(flags_o.c)) && (flags_o.ov == $past(flags_o.ov)) && wr_en_o)
      else $error("shift changed carry or overflow");
   AST_REVERSE_SUBTRACT_WITH_BORROW_OP_RESULT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ready_o && req_i.valid && req_i.op == SSTD_OP_REVERSE_SUBTRACT_WITH_BORROW_OP) |=>
         wr_data_o == $past(req_i.b) - $past(req_i.a) - {15'h0000, ~$past(flags_o.c)})
      else $error("reverse subtract result wrong");
   AST_SUBTRACT_WITH_BORROW_OP_RESULT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ready_o && req_i.valid && req_i.op == SSTD_OP_SUBTRACT_WITH_BORROW_OP && req_i.use_lit) |=>
         wr_data_o == $past(req_i.a) - {11'h000, $past(req_i.lit)} - {15'h0000, ~$past(flags_o.c)})
      else $error("subtract with borrow result wrong");
   AST_ZE_RESULT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ready_o && req_i.valid && req_i.op == SSTD_OP_ZERO_EXTEND) |=>
         (wr_data_o[15:8] == 8'h00) && (wr_data_o[7:0] == $past(req_i.a[7:0])) && !flags_o.n)
      else $error("zero extend wrong");
   AST_TRH_TWO: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ready_o && req_i.valid && req_i.op == SSTD_OP_TBL_READ_HI) |=>
         pm_rd_o && !done_o ##1 done_o && wr_en_o && wr_data_o == {8'h00, $past(pm_rdata_i[23:16])})
      else $error("table read high timing or data wrong");
   AST_TRL_TWO: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ready_o && req_i.valid && req_i.op == SSTD_OP_TBL_READ_LO) |=>
         $stable(flags_o) ##1 done_o && wr_data_o == $past(pm_rdata_i[15:0]) && $stable(flags_o))
      else $error("table read low wrong");
   AST_TWH_DATA: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ready_o && req_i.valid && req_i.op == SSTD_OP_TBL_WRITE_HI) |=>
         pm_wr_o && pm_wr_hi_o && pm_wdata_o[23:16] == $past(req_i.a[7:0]) ##1 done_o && !wr_en_o)
      else $error("table write high wrong");
   AST_TWL_DATA: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ready_o && req_i.valid && req_i.op == SSTD_OP_TBL_WRITE_LO) |=>
         pm_wr_o && !pm_wr_hi_o && pm_wdata_o[15:0] == $past(req_i.a) ##1 done_o && $stable(flags_o))
      else $error("table write low wrong");
   AST_BUSY_ONE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !ready_o |=> ready_o && done_o && !pm_rd_o && !pm_wr_o && (flags_o == $past(flags_o)))
      else $error("table access did not end after its second cycle");
   AST_SHIFT_DATA: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ready_o && req_i.valid && req_i.op == SSTD_OP_SHIFT_LEFT) |=>
         wr_data_o == ($past(req_i.a) << ($past(req_i.use_lit) ? $past(req_i.lit[3:0]) : $past(req_i.b[3:0]))))
      else $error("shift result wrong");
   AST_SHIFT_NZ: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ready_o && req_i.valid && req_i.op == SSTD_OP_SHIFT_LEFT) |=>
         (flags_o.z == (wr_data_o == 16'h0000)) && (flags_o.n == wr_data_o[15]) && $stable(flags_o.dc))
      else $error("shift zero or negative flag wrong");
   AST_SUB_NZ: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ready_o && req_i.valid && (req_i.op == SSTD_OP_SUBTRACT_WITH_BORROW_OP || req_i.op == SSTD_OP_REVERSE_SUBTRACT_WITH_BORROW_OP)) |=>
         (flags_o.z == (wr_data_o == 16'h0000)) && (flags_o.n == wr_data_o[15]))
      else $error("subtract zero or negative flag wrong");
   AST_ZE_FLAGS: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ready_o && req_i.valid && req_i.op == SSTD_OP_ZERO_EXTEND) |=>
         flags_o.c && (flags_o.z == (wr_data_o == 16'h0000)) && $stable(flags_o.dc) && $stable(flags_o.ov))
      else $error("zero extend flags wrong");
endmodule : sstd_datapath
`default_nettype wire

// File: verilog/sstd_pkg.sv
`default_nettype none
package sstd_pkg;
   // ==========================================================
   // widths
   localparam int SSTD_DW   = 16;
   localparam int SSTD_PW   = 24;
   localparam int SSTD_AW   = 16;
   localparam int SSTD_LITW = 5;
   localparam int SSTD_RW   = 4;
   localparam int SSTD_SHW  = 4;
   // ==========================================================
   // program word field positions
   localparam int SSTD_PHI_LSB = 16;
   localparam int SSTD_PHI_MSB = 23;
   localparam int SSTD_BYTE_MSB = 7;
   localparam int SSTD_NIB_MSB  = 3;
   // ==========================================================
   // reset values
   localparam logic [SSTD_DW-1:0] SSTD_DATA_RST = 16'h0000;
   localparam logic [SSTD_PW-1:0] SSTD_PROG_RST = 24'h000000;
   // table access length in instruction cycles
   localparam int SSTD_TBL_CYCLES = 2;

   typedef enum logic [3:0] {
      SSTD_OP_SHIFT_LEFT    = 4'h0,
      SSTD_OP_SUBTRACT_WITH_BORROW_OP          = 4'h1,
      SSTD_OP_REVERSE_SUBTRACT_WITH_BORROW_OP         = 4'h2,
      SSTD_OP_ZERO_EXTEND   = 4'h3,
      SSTD_OP_TBL_READ_HI   = 4'h4,
      SSTD_OP_TBL_READ_LO   = 4'h5,
      SSTD_OP_TBL_WRITE_HI  = 4'h6,
      SSTD_OP_TBL_WRITE_LO  = 4'h7
   } sstd_op_t;

   typedef struct packed {
      logic c;
      logic dc;
      logic n;
      logic ov;
      logic z;
   } sstd_flags_t;

   typedef struct packed {
      logic                 valid;
      sstd_op_t             op;
      logic                 use_lit;
      logic [SSTD_LITW-1:0] lit;
      logic [SSTD_DW-1:0]   a;
      logic [SSTD_DW-1:0]   b;
      logic [SSTD_RW-1:0]   dst;
      logic [SSTD_AW-1:0]   addr;
   } sstd_req_t;

   typedef enum logic [1:0] {
      SSTD_ST_IDLE  = 2'b01,
      SSTD_ST_TABLE = 2'b10
   } sstd_state_t;

   typedef struct packed {
      sstd_state_t        st;
      sstd_op_t           op;
      logic [SSTD_RW-1:0] dst;
      logic [SSTD_AW-1:0] addr;
      logic               wr_en;
      logic [SSTD_RW-1:0] wr_dst;
      logic [SSTD_DW-1:0] wr_data;
      sstd_flags_t        flags;
      logic               pm_rd;
      logic               pm_wr;
      logic               pm_wr_hi;
      logic [SSTD_PW-1:0] pm_wdata;
      logic               done;
   } sstd_regs_t;
endpackage : sstd_pkg
`default_nettype wire
